// file: rtl/utx_endpoint.sv
// module: transmit control and endpoint configuration of one full-speed endpoint
`timescale 1ns/1ps

// Function
// - iso with ignore-mask set sends queued data at the next IN.
// - iso with ignore-mask clear sends only when frame lsb equals toggle.
// - warn limit code 00 off, 01 fewer than 5, 10 fewer than 17 bytes.
// - warn event set when bytes left are at or below the limit.
// - warn event only while transmit enable is set.
// - setting last marker saves the current read pointer.
// - refill reloads the saved pointer after transmission, then self-clears.
// - flush empties fifo, clears last marker, zeroes pointers after transmission, self-clears.
// - non-iso sends DATA0 for toggle 0 and DATA1 for toggle 1.
// - iso with ignore-mask clear, frame match but no IN discards the fifo at next SOF.
// - iso always sends DATA0.
// - fifo empty mid-packet without last marker forces stuff error then EOP.
// - last marker with no data gives a zero-length packet.
// - payload and CRC16 are sent before the last marker clears, as EOP is queued.
// - transmit enable clears after one packet or any stall, on an IN or an OUT token.
// - stall answers IN when tx enabled and OUT when rx enabled.
// - stall never answers a SETUP token.
// - enabled but not ready iso endpoint sends no handshake.
// - active bit gates matching on endpoint number and address.
// - a four-bit endpoint number is held for matching.
// - underrun flag set on mid-packet empty, cleared by status read.
module utx_endpoint
  import utx_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  input  wire utx_token_s  token_in,
  input  wire logic        sof_in,
  input  wire logic [7:0]  frame_num_in,
  input  wire logic        rx_enable_in,
  input  wire logic        rx_fifo_full_in,
  input  wire logic        ack_in,
  input  wire logic        tx_ready_in,
  output utx_tx_s          tx_out,
  output logic      [3:0]  tx_pid_out,
  output logic             tx_warn_event_out
);

  // ------------------------------------------------------------
  // registers and fifo storage
  // ------------------------------------------------------------
  logic [7:0]           tx_ctrl_q;
  logic [7:0]           ep_cfg_q;
  logic [6:0]           func_addr_q;
  logic [7:0]           frame_lo_q;
  logic [7:0]           fifo_mem [UTX_FIFO_DEPTH];
  logic [UTX_PTR_W:0]   wptr_q;
  logic [UTX_PTR_W:0]   rptr_q;
  logic [UTX_PTR_W:0]   saved_rptr_q;
  logic                 tx_underrun_flag_q;
  logic                 ack_stat_q;
  logic                 done_q;
  logic                 iso_armed_q;
  utx_state_e           state_q;
  logic [15:0]          crc_q;
  logic                 crc_hi_q;
  logic [15:0]          rdata_q;
  utx_tx_s              tx_q;
  logic [3:0]           pid_q;
  logic                 warn_q;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // address match used by both the write and read paths
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    return a == r;
  endfunction

  logic               busy;
  logic               fifo_empty;
  logic [UTX_PTR_W:0] level;
  logic [6:0]         limit;
  logic               tok_match;
  logic               iso;
  logic               frame_ok;
  logic               wr_ctrl;
  logic               start_tx;
  logic               send_stall;
  logic               take;

  assign busy       = state_q != UTX_ST_IDLE;
  assign take       = !tx_q.valid || tx_ready_in;
  assign level      = wptr_q - rptr_q;
  assign fifo_empty = level == '0;
  assign iso        = ep_cfg_q[UTX_EPC_ISO];
  assign wr_ctrl    = wr_in && hit(addr_in, UTX_ADDR_TX_CTRL);
  // token matching on function address and endpoint number
  assign tok_match  = token_in.valid && ep_cfg_q[UTX_EPC_ACTIVE]
                      && token_in.addr == func_addr_q
                      && token_in.ep == ep_cfg_q[3:0];
  // iso frame lock unless ignore-mask set
  assign frame_ok   = tx_ctrl_q[UTX_TXC_IGNMSK]
                      || (frame_lo_q[0] == tx_ctrl_q[UTX_TXC_TOGGLE]);
  assign send_stall = tok_match && ep_cfg_q[UTX_EPC_STALL] && !busy
                      && ((token_in.kind == UTX_TOK_IN && tx_ctrl_q[UTX_TXC_EN])
                      || (token_in.kind == UTX_TOK_OUT && rx_enable_in));
  // data only when enabled, last marker set or fifo not empty, and (iso) frame matches
  assign start_tx   = tok_match && token_in.kind == UTX_TOK_IN && !busy
                      && !ep_cfg_q[UTX_EPC_STALL] && tx_ctrl_q[UTX_TXC_EN]
                      && (!iso || frame_ok)
                      && (tx_ctrl_q[UTX_TXC_LAST] || !fifo_empty);

  // warning threshold, code 11 treated as off
  always_comb begin
    case (tx_ctrl_q[UTX_TXC_WL_LO +: 2])
      UTX_WL_LT5:  limit = UTX_LIM_LT5;
      UTX_WL_LT17: limit = UTX_LIM_LT17;
      default:     limit = '0;
    endcase
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  // endpoint config, address and frame low byte
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      ep_cfg_q    <= UTX_REG_RESET[7:0];
      func_addr_q <= UTX_REG_RESET[6:0];
      frame_lo_q  <= UTX_REG_RESET[7:0];
    end else begin
      if (wr_in && hit(addr_in, UTX_ADDR_EP_CFG)) begin
        ep_cfg_q <= wdata_in[7:0] & 8'hBF;
      end
      if (wr_in && hit(addr_in, UTX_ADDR_FUNC_ADDR)) begin
        func_addr_q <= wdata_in[6:0];
      end
      if (sof_in) begin
        frame_lo_q <= frame_num_in;
      end
    end
  end

  // transmit control; hardware clears win over firmware writes of same bit
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      tx_ctrl_q <= UTX_REG_RESET[7:0];
    end else begin
      if (wr_ctrl) begin
        tx_ctrl_q <= wdata_in[7:0];
      end
      if (state_q == UTX_ST_EOP && take) begin
        tx_ctrl_q[UTX_TXC_LAST] <= 1'b0;
        tx_ctrl_q[UTX_TXC_EN]   <= 1'b0;
      end
      if (send_stall && token_in.kind == UTX_TOK_IN) begin
        tx_ctrl_q[UTX_TXC_EN] <= 1'b0;
      end
      if (!busy && tx_ctrl_q[UTX_TXC_REFILL]) begin
        tx_ctrl_q[UTX_TXC_REFILL] <= 1'b0;
      end
      if (!busy && tx_ctrl_q[UTX_TXC_FLUSH]) begin
        tx_ctrl_q[UTX_TXC_FLUSH] <= 1'b0;
        tx_ctrl_q[UTX_TXC_LAST]  <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // fifo pointers
  // ------------------------------------------------------------
  // write side, flush, refill, iso discard and read advance
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      wptr_q       <= '0;
      rptr_q       <= '0;
      saved_rptr_q <= '0;
    end else begin
      if (wr_in && hit(addr_in, UTX_ADDR_TX_DATA) && level < 7'(UTX_FIFO_DEPTH)) begin
        fifo_mem[wptr_q[UTX_PTR_W-1:0]] <= wdata_in[7:0];
        wptr_q <= wptr_q + 1'b1;
      end
      if (wr_ctrl && wdata_in[UTX_TXC_LAST] && !tx_ctrl_q[UTX_TXC_LAST]) begin
        saved_rptr_q <= rptr_q;
      end
      if (state_q == UTX_ST_DATA && take && !fifo_empty) begin
        rptr_q <= rptr_q + 1'b1;
      end
      if (!busy && tx_ctrl_q[UTX_TXC_REFILL]) begin
        rptr_q <= saved_rptr_q;
      end
      if ((!busy && tx_ctrl_q[UTX_TXC_FLUSH]) || (sof_in && iso_armed_q)) begin
        wptr_q <= '0;
        rptr_q <= '0;
      end
    end
  end

  // ------------------------------------------------------------
  // transmit state machine
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_q  <= UTX_ST_IDLE;
      tx_q     <= '0;
      pid_q    <= '0;
      crc_q    <= '1;
      crc_hi_q <= 1'b0;
    end else begin
      tx_q.valid <= tx_q.valid && !tx_ready_in;
      case (state_q)
        UTX_ST_IDLE: begin
          crc_q <= '1;
          if (send_stall) begin
            pid_q   <= UTX_PID_STALL;
            state_q <= UTX_ST_HSK;
          end else if (start_tx) begin
            // iso always DATA0, otherwise toggle picks the pid
            pid_q   <= (iso || !tx_ctrl_q[UTX_TXC_TOGGLE])
                       ? UTX_PID_DATA0 : UTX_PID_DATA1;
            state_q <= UTX_ST_PID;
          end
        end
        UTX_ST_PID, UTX_ST_HSK: begin
          if (take) begin
            tx_q    <= '{valid: 1'b1, pid: 1'b1, crc: 1'b0, eop: 1'b0,
                         stuff_err: 1'b0, data: {~pid_q, pid_q}};
            state_q <= (state_q == UTX_ST_HSK) ? UTX_ST_EOP : UTX_ST_DATA;
          end
        end
        UTX_ST_DATA: begin
          if (fifo_empty) begin
            // empty with last set ends the payload, else underrun
            state_q <= tx_ctrl_q[UTX_TXC_LAST] ? UTX_ST_CRC : UTX_ST_ERR;
          end else if (take) begin
            tx_q  <= '{valid: 1'b1, pid: 1'b0, crc: 1'b0, eop: 1'b0,
                       stuff_err: 1'b0, data: fifo_mem[rptr_q[UTX_PTR_W-1:0]]};
            crc_q <= crc16(crc_q, fifo_mem[rptr_q[UTX_PTR_W-1:0]]);
          end
        end
        UTX_ST_CRC: begin
          if (take) begin
            tx_q     <= '{valid: 1'b1, pid: 1'b0, crc: 1'b1, eop: 1'b0, stuff_err: 1'b0,
                          data: crc_hi_q ? ~crc_q[15:8] : ~crc_q[7:0]};
            crc_hi_q <= !crc_hi_q;
            if (crc_hi_q) begin
              state_q <= UTX_ST_EOP;
            end
          end
        end
        UTX_ST_ERR: begin
          if (take) begin
            tx_q    <= '{valid: 1'b1, pid: 1'b0, crc: 1'b0, eop: 1'b0,
                         stuff_err: 1'b1, data: 8'h00};
            state_q <= UTX_ST_EOP;
          end
        end
        UTX_ST_EOP: begin
          if (take) begin
            tx_q    <= '{valid: 1'b1, pid: 1'b0, crc: 1'b0, eop: 1'b1,
                         stuff_err: 1'b0, data: 8'h00};
            state_q <= UTX_ST_IDLE;
          end
        end
        default: state_q <= UTX_ST_IDLE;
      endcase
    end
  end

  // usb crc16 over one byte, lsb first
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  // sticky flags; a set in the read cycle wins over the read clear
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      tx_underrun_flag_q <= 1'b0;
      ack_stat_q         <= 1'b0;
      done_q             <= 1'b0;
      iso_armed_q        <= 1'b0;
      warn_q             <= 1'b0;
    end else begin
      if (rd_in && hit(addr_in, UTX_ADDR_TX_STATUS)) begin
        tx_underrun_flag_q <= 1'b0;
        ack_stat_q         <= 1'b0;
        done_q             <= 1'b0;
      end
      if (state_q == UTX_ST_DATA && fifo_empty && !tx_ctrl_q[UTX_TXC_LAST]) begin
        tx_underrun_flag_q <= 1'b1;
      end
      if (state_q == UTX_ST_EOP && take) begin
        done_q <= 1'b1;
      end
      if (ack_in && !iso) begin
        ack_stat_q <= 1'b1;
      end
      // iso slot armed while frame matches, enabled and ignore-mask clear; cleared by IN or SOF
      if (start_tx || sof_in) begin
        iso_armed_q <= 1'b0;
      end else if (iso && tx_ctrl_q[UTX_TXC_EN] && frame_ok && !tx_ctrl_q[UTX_TXC_IGNMSK]) begin
        iso_armed_q <= 1'b1;
      end
      if (sof_in && iso_armed_q) begin
        done_q <= 1'b1;
      end
      // warning only while transmit is enabled
      warn_q <= tx_ctrl_q[UTX_TXC_EN] && limit != '0
                && {1'b0, level} <= 8'(limit);
    end
  end

  // ------------------------------------------------------------
  // read path and outputs
  // ------------------------------------------------------------
  logic [4:0] free_cnt;
  assign free_cnt = (7'(UTX_FIFO_DEPTH) - level > 7'(UTX_FREE_MAX))
                    ? UTX_FREE_MAX : 5'(7'(UTX_FIFO_DEPTH) - level);

  // read data valid one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      rdata_q <= '0;
    end else if (rd_in) begin
      if (hit(addr_in, UTX_ADDR_TX_CTRL)) begin
        rdata_q <= {8'h00, tx_ctrl_q};
      end else if (hit(addr_in, UTX_ADDR_EP_CFG)) begin
        rdata_q <= {8'h00, ep_cfg_q};
      end else if (hit(addr_in, UTX_ADDR_TX_STATUS)) begin
        rdata_q <= {8'h00, tx_underrun_flag_q, ack_stat_q, done_q, free_cnt};
      end else if (hit(addr_in, UTX_ADDR_FUNC_ADDR)) begin
        rdata_q <= {9'h000, func_addr_q};
      end else if (hit(addr_in, UTX_ADDR_FRAME_LO)) begin
        rdata_q <= {8'h00, frame_lo_q};
      end else begin
        rdata_q <= '0;
      end
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata_out         = rdata_q;
  assign tx_out            = tx_q;
  assign tx_pid_out        = pid_q;
  assign tx_warn_event_out = warn_q;

endmodule // utx_endpoint

// file: rtl/utx_pkg.sv
// package: register map, field layout and shared types of the tx endpoint control
package utx_pkg;

  // ------------------------------------------------------------
  // register offsets (printed offsets are not all multiples of 4)
  // ------------------------------------------------------------
  localparam logic [31:0] UTX_ADDR_TX_DATA   = 32'h5000_1862;
  localparam logic [31:0] UTX_ADDR_TX_STATUS = 32'h5000_1864;
  localparam logic [31:0] UTX_ADDR_TX_CTRL   = 32'h5000_1866;
  localparam logic [31:0] UTX_ADDR_EP_CFG    = 32'h5000_1868;
  localparam logic [31:0] UTX_ADDR_FRAME_LO  = 32'h5000_1870;
  localparam logic [31:0] UTX_ADDR_FUNC_ADDR = 32'h5000_1872;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int UTX_TXC_EN      = 0;
  localparam int UTX_TXC_LAST    = 1;
  localparam int UTX_TXC_TOGGLE  = 2;
  localparam int UTX_TXC_FLUSH   = 3;
  localparam int UTX_TXC_REFILL  = 4;
  localparam int UTX_TXC_WL_LO   = 5;
  localparam int UTX_TXC_IGNMSK  = 7;
  localparam int UTX_EPC_ACTIVE  = 4;
  localparam int UTX_EPC_ISO     = 5;
  localparam int UTX_EPC_STALL   = 7;
  localparam int UTX_TXS_URUN    = 7;
  localparam int UTX_TXS_WARN    = 6;
  localparam int UTX_TXS_DONE    = 5;

  // ------------------------------------------------------------
  // reset values, sizes and codes
  // ------------------------------------------------------------
  localparam logic [15:0] UTX_REG_RESET  = 16'h0000;
  localparam int          UTX_FIFO_DEPTH = 64;
  localparam int          UTX_PTR_W      = 6;
  localparam logic [1:0]  UTX_WL_OFF     = 2'h0;
  localparam logic [1:0]  UTX_WL_LT5     = 2'h1;
  localparam logic [1:0]  UTX_WL_LT17    = 2'h2;
  localparam logic [6:0]  UTX_LIM_LT5    = 7'h04;
  localparam logic [6:0]  UTX_LIM_LT17   = 7'h10;
  localparam logic [4:0]  UTX_FREE_MAX   = 5'h1F;
  localparam logic [3:0]  UTX_PID_DATA0  = 4'h3;
  localparam logic [3:0]  UTX_PID_DATA1  = 4'hB;
  localparam logic [3:0]  UTX_PID_STALL  = 4'hE;
  localparam logic [3:0]  UTX_PID_NAK    = 4'hA;

  // token kinds from the serial engine
  typedef enum logic [1:0] {
    UTX_TOK_IN    = 2'b00,
    UTX_TOK_OUT   = 2'b01,
    UTX_TOK_SETUP = 2'b10,
    UTX_TOK_NONE  = 2'b11
  } utx_tok_e;

  // decoded token from the serial engine
  typedef struct packed {
    logic       valid;
    utx_tok_e   kind;
    logic [6:0] addr;
    logic [3:0] ep;
  } utx_token_s;

  // byte stream toward the serial engine
  typedef struct packed {
    logic       valid;
    logic       pid;
    logic       crc;
    logic       eop;
    logic       stuff_err;
    logic [7:0] data;
  } utx_tx_s;

  // transmit state machine
  typedef enum logic [2:0] {
    UTX_ST_IDLE  = 3'b000,
    UTX_ST_PID   = 3'b001,
    UTX_ST_DATA  = 3'b010,
    UTX_ST_CRC   = 3'b011,
    UTX_ST_EOP   = 3'b100,
    UTX_ST_ERR   = 3'b101,
    UTX_ST_HSK   = 3'b110
  } utx_state_e;

endpackage

// file: verification/utx_endpoint_chk.sv
// checker: port assertions of the tx endpoint control
`timescale 1ns/1ps
module utx_endpoint_chk
  import utx_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        resetn_in,
  input wire logic [31:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  input wire utx_token_s  token_in,
  input wire logic        sof_in,
  input wire logic [7:0]  frame_num_in,
  input wire logic        rx_enable_in,
  input wire logic        rx_fifo_full_in,
  input wire logic        ack_in,
  input wire logic        tx_ready_in,
  input wire utx_tx_s     tx_out,
  input wire logic [3:0]  tx_pid_out,
  input wire logic        tx_warn_event_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  // ----
  // steps of a transfer
  // ----
  sequence stall_s;
    tx_out.valid && tx_out.pid && tx_ready_in && tx_pid_out == UTX_PID_STALL;
  endsequence
  sequence err_s;
    tx_out.valid && tx_out.stuff_err && tx_ready_in;
  endsequence
  sequence crc_s;
    tx_out.valid && tx_out.crc && tx_ready_in;
  endsequence
  sequence eop_s;
    tx_out.valid && tx_out.eop;
  endsequence

  a_setup_no_stall: assert property (
    token_in.valid && token_in.kind == UTX_TOK_SETUP && !tx_out.valid && !$past(token_in.valid)
    |-> ##2 !(tx_out.valid && tx_out.pid && tx_pid_out == UTX_PID_STALL))
    else $error("stall sent for a setup token");
  a_stall_eop_soon: assert property (stall_s |-> ##[1:20] eop_s)
    else $error("stall id not closed by eop");
  a_stall_no_data: assert property (
    stall_s |=> (!tx_out.valid || tx_out.eop) until_with eop_s)
    else $error("data after stall id");
  a_err_eop_soon: assert property (err_s |-> ##[1:20] eop_s)
    else $error("stuff error not closed by eop");
  a_err_then_eop: assert property (
    err_s |=> (!tx_out.valid || tx_out.eop) until_with eop_s)
    else $error("byte between stuff error and eop");
  a_crc_next_end: assert property (
    crc_s |=> !tx_out.valid until (tx_out.valid && (tx_out.crc || tx_out.eop)))
    else $error("crc byte followed by payload");
  a_crc_eop_soon: assert property (crc_s |-> ##[1:20] eop_s)
    else $error("crc not closed by eop");
  a_byte_held: assert property (
    tx_out.valid && !tx_ready_in |=> tx_out.valid && $stable(tx_out))
    else $error("offered byte dropped while not taken");
endmodule // utx_endpoint_chk

bind utx_endpoint utx_endpoint_chk u_chk (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .token_in(token_in), .sof_in(sof_in),
  .frame_num_in(frame_num_in), .rx_enable_in(rx_enable_in), .rx_fifo_full_in(rx_fifo_full_in),
  .ack_in(ack_in), .tx_ready_in(tx_ready_in), .tx_out(tx_out), .tx_pid_out(tx_pid_out),
  .tx_warn_event_out(tx_warn_event_out));

// file: verification/utx_host_model.sv
// partner: host controller on the bus, tokens, frame starts and byte sink
`timescale 1ns/1ps
module utx_host_model
  import utx_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       slow_in,
  input  wire utx_tx_s    tx_in,
  input  wire logic [3:0] tx_pid_in,
  output utx_token_s      token_out,
  output logic            sof_out,
  output logic [7:0]      frame_num_out,
  output logic            ack_out,
  output logic            tx_ready_out
);
  logic data_pkt_q;

  // idle bus at time zero
  initial begin
    token_out = '{1'b0, UTX_TOK_NONE, 7'h00, 4'h0};
    sof_out = 1'b0;
    frame_num_out = 8'h00;
    ack_out = 1'b0;
    tx_ready_out = 1'b1;
    data_pkt_q = 1'b0;
  end

  // sink: a slow host stalls one cycle at most; ack only clean data packets
  always @(posedge ref_clk_in) begin
    tx_ready_out <= !slow_in || !tx_ready_out || 1'($urandom_range(1));
    if (tx_in.valid && tx_ready_out && (tx_in.pid || tx_in.stuff_err)) begin
      data_pkt_q <= tx_in.pid && tx_pid_in != UTX_PID_STALL;
    end
    ack_out <= tx_in.valid && tx_in.eop && tx_ready_out && data_pkt_q;
  end

  // one token for one cycle, then fields scrambled
  task automatic send_token(input utx_tok_e k, input logic [6:0] a, input logic [3:0] e);
    token_out <= '{1'b1, k, a, e};
    @(posedge ref_clk_in);
    token_out <= '{1'b0, UTX_TOK_NONE, ~a, ~e};
  endtask

  // frame start pulse with low frame byte
  task automatic send_sof(input logic [7:0] f);
    sof_out <= 1'b1;
    frame_num_out <= f;
    @(posedge ref_clk_in);
    sof_out <= 1'b0;
    frame_num_out <= ~f;
  endtask
endmodule // utx_host_model

// file: verification/utx_endpoint_tb.sv
// testbench: self-checking run of the tx endpoint control
`timescale 1ns/1ps
module utx_endpoint_tb
  import utx_pkg::*;
();
  localparam logic [6:0] FADDR = 7'h05;
  localparam logic [3:0] EPN   = 4'h3;
  logic        ref_clk_in, resetn_in, wr_in, rd_in, rd_d, rx_enable_in, slow;
  logic        sof_in, ack_in, tx_ready_in, tx_warn_event_out;
  logic [31:0] addr_in;
  logic [15:0] wdata_in, rdata_out;
  logic [7:0]  frame_num_in;
  logic [3:0]  tx_pid_out;
  utx_token_s  token_in;
  utx_tx_s     tx_out;
  logic [31:0] rq[$];
  logic [11:0] tq[$];
  logic [7:0]  pay[$];
  int          failures, total_checks, cyc;

  utx_endpoint u_dut (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .token_in(token_in), .sof_in(sof_in),
    .frame_num_in(frame_num_in), .rx_enable_in(rx_enable_in), .rx_fifo_full_in(slow),
    .ack_in(ack_in), .tx_ready_in(tx_ready_in), .tx_out(tx_out), .tx_pid_out(tx_pid_out),
    .tx_warn_event_out(tx_warn_event_out));
  utx_host_model u_host (
    .ref_clk_in(ref_clk_in), .slow_in(slow), .tx_in(tx_out), .tx_pid_in(tx_pid_out),
    .token_out(token_in), .sof_out(sof_in), .frame_num_out(frame_num_in), .ack_out(ack_in),
    .tx_ready_out(tx_ready_in));

  // 100 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // register bus: one strobe cycle, then idle
  task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
  endtask
  task automatic rd_reg(input logic [31:0] a, input logic [15:0] m, input logic [15:0] v);
    rq.push_back({m, v});
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  // random payload into the fifo
  task automatic put_data(input int n);
    logic [7:0] b;
    pay.delete();
    repeat (n) begin
      b = 8'($urandom);
      pay.push_back(b);
      wr_reg(UTX_ADDR_TX_DATA, {8'h00, b});
    end
  endtask

  // note a packet: id, payload, then crc pair or stuff error, then eop
  task automatic exp_pkt(input logic [3:0] p, input logic last);
    tq.push_back({4'b1000, 4'h0, p});
    foreach (pay[i]) tq.push_back({4'b0000, pay[i]});
    if (last) begin
      tq.push_back({4'b0100, 8'h00});
      tq.push_back({4'b0100, 8'h00});
    end else begin
      tq.push_back({4'b0001, 8'h00});
    end
    tq.push_back({4'b0010, 8'h00});
  endtask

  // token, then wait for the noted bytes to drain
  task automatic tok(input utx_tok_e k, input logic [3:0] e);
    u_host.send_token(k, FADDR, e);
    repeat (8) @(posedge ref_clk_in);
    for (int i = 0; i < 100 && tq.size() != 0; i++) @(posedge ref_clk_in);
    chk(tq.size() == 0, "packet bytes missing");
    repeat (3) @(posedge ref_clk_in);
  endtask

  task automatic endt(input string s);
    $display("test %s finished", s);
  endtask

  // monitor: each read or taken byte against the oldest note
  always @(posedge ref_clk_in) begin
    logic [31:0] r;
    logic [11:0] t;
    rd_d <= rd_in;
    if (rd_d) begin
      r = rq.pop_front();
      chk((rdata_out & r[31:16]) === r[15:0], "register read");
    end
    if (tx_out.valid && tx_ready_in) begin
      t = (tq.size() != 0) ? tq.pop_front() : 12'hFFF;
      chk({tx_out.pid, tx_out.crc, tx_out.eop, tx_out.stuff_err} === t[11:8], "byte kind");
      if (t[11]) chk(tx_pid_out === t[3:0], "packet id");
      if (t[11:8] == 4'h0) chk(tx_out.data === t[7:0], "payload byte");
    end
  end

  // hang guard
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    {resetn_in, wr_in, rd_in, rd_d, rx_enable_in, slow} = 6'h00;
    addr_in = 32'h0000_0000;
    wdata_in = 16'h0000;
    void'($urandom(32'h27b7_f781));
    repeat (20) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_reg(UTX_ADDR_TX_CTRL, 16'hFFFF, 16'h0000);
    rd_reg(UTX_ADDR_EP_CFG, 16'hFFFF, 16'h0000);
    rd_reg(UTX_ADDR_TX_STATUS, 16'hFFFF, 16'h001F);
    wr_reg(32'h5000_1880, 16'h00FF);
    rd_reg(32'h5000_1880, 16'hFFFF, 16'h0000);
    wr_reg(UTX_ADDR_FUNC_ADDR, {9'h000, FADDR});
    wr_reg(UTX_ADDR_EP_CFG, 16'hFF13);
    rd_reg(UTX_ADDR_EP_CFG, 16'hFFFF, 16'h0013);
    endt("registers");
    for (int t = 0; t < 2; t++) begin
      slow <= t[0];
      put_data(1 + $urandom_range(3));
      wr_reg(UTX_ADDR_TX_CTRL, {13'h0000, t[0], 2'b11});
      tok(UTX_TOK_IN, 4'h4);
      exp_pkt(t[0] ? UTX_PID_DATA1 : UTX_PID_DATA0, 1'b1);
      tok(UTX_TOK_IN, EPN);
      rd_reg(UTX_ADDR_TX_CTRL, 16'h0003, 16'h0000);
    end
    pay.delete();
    exp_pkt(UTX_PID_DATA0, 1'b1);
    wr_reg(UTX_ADDR_TX_CTRL, 16'h0003);
    tok(UTX_TOK_IN, EPN);
    put_data(1);
    exp_pkt(UTX_PID_DATA0, 1'b0);
    wr_reg(UTX_ADDR_TX_CTRL, 16'h0001);
    tok(UTX_TOK_IN, EPN);
    rd_reg(UTX_ADDR_TX_STATUS, 16'h0080, 16'h0080);
    rd_reg(UTX_ADDR_TX_STATUS, 16'h0080, 16'h0000);
    endt("data packets");
    put_data(2);
    exp_pkt(UTX_PID_DATA0, 1'b1);
    wr_reg(UTX_ADDR_TX_CTRL, 16'h0003);
    tok(UTX_TOK_IN, EPN);
    wr_reg(UTX_ADDR_TX_CTRL, 16'h0010);
    rd_reg(UTX_ADDR_TX_CTRL, 16'h0010, 16'h0000);
    exp_pkt(UTX_PID_DATA0, 1'b1);
    wr_reg(UTX_ADDR_TX_CTRL, 16'h0003);
    tok(UTX_TOK_IN, EPN);
    put_data(3);
    wr_reg(UTX_ADDR_TX_CTRL, 16'h0008);
    rd_reg(UTX_ADDR_TX_CTRL, 16'h0008, 16'h0000);
    rd_reg(UTX_ADDR_TX_STATUS, 16'h00FF, 16'h007F);
    endt("refill and flush");
    put_data(4);
    for (int c = 0; c < 4; c++) begin
      wr_reg(UTX_ADDR_TX_CTRL, {9'h000, c[1:0], 5'h00});
      chk(tx_warn_event_out === 1'b0, "warning while disabled");
      wr_reg(UTX_ADDR_TX_CTRL, {9'h000, c[1:0], 5'h01});
      chk(tx_warn_event_out === (c == 1 || c == 2), "warning level");
    end
    wr_reg(UTX_ADDR_TX_DATA, 16'h00A5);
    wr_reg(UTX_ADDR_TX_CTRL, 16'h0021);
    chk(tx_warn_event_out === 1'b0, "warning above limit");
    wr_reg(UTX_ADDR_TX_CTRL, 16'h0008);
    endt("warning");
    wr_reg(UTX_ADDR_EP_CFG, 16'h0093);
    wr_reg(UTX_ADDR_TX_CTRL, 16'h0001);
    tok(UTX_TOK_SETUP, EPN);
    tq.push_back({4'b1000, 4'h0, UTX_PID_STALL});
    tq.push_back({4'b0010, 8'h00});
    tok(UTX_TOK_IN, EPN);
    rd_reg(UTX_ADDR_TX_CTRL, 16'h0001, 16'h0000);
    rx_enable_in <= 1'b1;
    tq.push_back({4'b1000, 4'h0, UTX_PID_STALL});
    tq.push_back({4'b0010, 8'h00});
    tok(UTX_TOK_OUT, EPN);
    rx_enable_in <= 1'b0;
    endt("stall");
    wr_reg(UTX_ADDR_EP_CFG, 16'h0033);
    wr_reg(UTX_ADDR_TX_CTRL, 16'h0081);
    tok(UTX_TOK_IN, EPN);
    u_host.send_sof(8'h00);
    put_data(2);
    wr_reg(UTX_ADDR_TX_CTRL, 16'h0007);
    tok(UTX_TOK_IN, EPN);
    u_host.send_sof(8'h01);
    exp_pkt(UTX_PID_DATA0, 1'b1);
    tok(UTX_TOK_IN, EPN);
    u_host.send_sof(8'h02);
    put_data(1);
    exp_pkt(UTX_PID_DATA0, 1'b1);
    wr_reg(UTX_ADDR_TX_CTRL, 16'h0087);
    tok(UTX_TOK_IN, EPN);
    rd_reg(UTX_ADDR_TX_STATUS, 16'h0020, 16'h0020);
    put_data(2);
    wr_reg(UTX_ADDR_TX_CTRL, 16'h0003);
    u_host.send_sof(8'h04);
    repeat (4) @(posedge ref_clk_in);
    u_host.send_sof(8'h05);
    repeat (3) @(posedge ref_clk_in);
    rd_reg(UTX_ADDR_TX_STATUS, 16'h003F, 16'h003F);
    endt("isochronous");
    close_out();
  end
endmodule // utx_endpoint_tb
